// >>> bridge_control_status_regs.sv
// control and status registers of the video serializer bridge
//
// What this block does
// - map bit chooses SPWG or OpenLDI lane arrangement
// - map bit loaded from strap after reset
// - pixel mode bit: 0 dual, 1 single, strapped
// - port swap: secondary port or exchange, resets 0
// - reload bit restarts memory load, self-clears
// - config done precedes initialization done
// - checksum of last 128 memory bytes reported
// - tdm enable serializes parallel audio data
// - audio source: 0 off, 1 pins, resets 1
// - tdm split enable, resets 0
// - eight-bit registers reached by offset over control bus
`timescale 1ns/1ps
module bridge_control_status_regs
  import bridge_regs_pkg::*;
#(
  parameter int W  = LANE_W,
  parameter int AW = NVM_AW
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata_ff,
  input  wire logic          strap_pin_one,
  input  wire logic          strap_pin_zero,
  input  wire logic [W-1:0]  port_a_lanes,
  input  wire logic [W-1:0]  port_b_lanes,
  output logic      [W-1:0]  primary_word_ff,
  output logic      [W-1:0]  secondary_word_ff,
  output logic               nvm_rd_ff,
  output logic      [AW-1:0] nvm_addr_ff,
  input  wire logic [7:0]    nvm_rdata,
  input  wire logic          nvm_valid,
  output logic               cfg_done_ff,
  output logic               init_done_ff,
  output logic               lane_bit_map_select_ff,
  output logic               input_pixel_mode_ff,
  output logic               input_port_swap_ff,
  output logic               audio_source_ff,
  output logic               tdm_serialize_ff,
  output logic               tdm_split_ff
);
  localparam int Q = W / 4;

  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  logic         straps_taken_ff;
  logic         cfg_reload_ff;
  logic         auto_init_ff;
  logic         cksum_ok;
  logic         seq_finish;
  logic [W-1:0] primary_word;
  logic [W-1:0] secondary_word;

  logic         nxt_straps_taken;
  logic         nxt_map;
  logic         nxt_pix;
  logic         nxt_swap;
  logic         nxt_cfg_reload;
  logic         nxt_auto_init;
  logic         nxt_audio_src;
  logic         nxt_tdm_ser;
  logic         nxt_tdm_split;
  logic [7:0]   nxt_rdata;
  logic         wr_ctl;
  logic         wr_aud;
  logic         wr_conv;

  assign wr_ctl  = reg_wr && (reg_addr == OFS_VIDEO_CTL);
  assign wr_aud  = reg_wr && (reg_addr == OFS_AUDIO_SET);
  assign wr_conv = reg_wr && (reg_addr == OFS_AUDIO_CONV);

  nvm_cksum_seq #(
    .AW (AW)
  ) u_seq (
    .clock        (clock),
    .rst_n        (rst_n_ff),
    .start_req    (cfg_reload_ff | auto_init_ff),
    .nvm_rdata    (nvm_rdata),
    .nvm_valid    (nvm_valid),
    .nvm_rd_ff    (nvm_rd_ff),
    .nvm_addr_ff  (nvm_addr_ff),
    .cfg_done_ff  (cfg_done_ff),
    .init_done_ff (init_done_ff),
    .cksum_ok_ff  (cksum_ok),
    .seq_finish   (seq_finish)
  );

  video_port_steer #(
    .W (W)
  ) u_steer (
    .lane_bit_map_select (lane_bit_map_select_ff),
    .input_pixel_mode    (input_pixel_mode_ff),
    .input_port_swap     (input_port_swap_ff),
    .port_a_lanes        (port_a_lanes),
    .port_b_lanes        (port_b_lanes),
    .primary_word        (primary_word),
    .secondary_word      (secondary_word)
  );

  always_comb begin
    nxt_straps_taken = 1'b1;
    nxt_map          = lane_bit_map_select_ff;
    nxt_pix          = input_pixel_mode_ff;
    nxt_swap         = input_port_swap_ff;
    nxt_audio_src    = audio_source_ff;
    nxt_tdm_ser      = tdm_serialize_ff;
    nxt_tdm_split    = tdm_split_ff;
    nxt_auto_init    = auto_init_ff && !seq_finish;
    nxt_cfg_reload   = cfg_reload_ff && !seq_finish;
    if (!straps_taken_ff) begin
      nxt_map       = strap_pin_one;
      nxt_pix       = strap_pin_zero;
      nxt_auto_init = 1'b1;
    end
    if (wr_ctl) begin
      nxt_map  = reg_wdata[BIT_MAP_SEL];
      nxt_pix  = reg_wdata[BIT_PIX_MODE];
      nxt_swap = reg_wdata[BIT_PORT_SWAP];
      // a new request in the finishing cycle wins over the self-clear
      if (reg_wdata[BIT_CFG_RELOAD]) begin
        nxt_cfg_reload = 1'b1;
      end
    end
    if (wr_aud) begin
      nxt_tdm_ser   = reg_wdata[BIT_TDM_EN];
      nxt_audio_src = reg_wdata[BIT_AUDIO_SRC];
    end
    if (wr_conv) begin
      nxt_tdm_split = reg_wdata[BIT_TDM_SPLIT];
    end
  end

  always_comb begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd) begin
      nxt_rdata = 8'h00;
      unique case (reg_addr)
        OFS_VIDEO_CTL: begin
          nxt_rdata[BIT_MAP_SEL]    = lane_bit_map_select_ff;
          nxt_rdata[BIT_PIX_MODE]   = input_pixel_mode_ff;
          nxt_rdata[BIT_PORT_SWAP]  = input_port_swap_ff;
          nxt_rdata[BIT_CFG_RELOAD] = cfg_reload_ff;
        end
        OFS_INIT_STS: begin
          nxt_rdata[BIT_INIT_DONE] = init_done_ff;
          nxt_rdata[BIT_CFG_DONE]  = cfg_done_ff;
          nxt_rdata[BIT_CKSUM_OK]  = cksum_ok;
        end
        OFS_AUDIO_SET: begin
          nxt_rdata[BIT_TDM_EN]    = tdm_serialize_ff;
          nxt_rdata[BIT_AUDIO_SRC] = audio_source_ff;
        end
        OFS_AUDIO_CONV: begin
          nxt_rdata[BIT_TDM_SPLIT] = tdm_split_ff;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      straps_taken_ff        <= 1'b0;
      lane_bit_map_select_ff <= MAP_SPWG;
      input_pixel_mode_ff    <= PIX_DUAL;
      input_port_swap_ff     <= RST_PORT_SWAP;
      cfg_reload_ff          <= RST_CFG_RELOAD;
      auto_init_ff           <= 1'b0;
      audio_source_ff        <= RST_AUDIO_SRC;
      tdm_serialize_ff       <= RST_TDM_EN;
      tdm_split_ff           <= RST_TDM_SPLIT;
      reg_rdata_ff           <= 8'h00;
      primary_word_ff        <= '0;
      secondary_word_ff      <= '0;
    end else begin
      straps_taken_ff        <= nxt_straps_taken;
      lane_bit_map_select_ff <= nxt_map;
      input_pixel_mode_ff    <= nxt_pix;
      input_port_swap_ff     <= nxt_swap;
      cfg_reload_ff          <= nxt_cfg_reload;
      auto_init_ff           <= nxt_auto_init;
      audio_source_ff        <= nxt_audio_src;
      tdm_serialize_ff       <= nxt_tdm_ser;
      tdm_split_ff           <= nxt_tdm_split;
      reg_rdata_ff           <= nxt_rdata;
      primary_word_ff        <= primary_word;
      secondary_word_ff      <= secondary_word;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n_ff);

  sequence strap_cycle;
    !straps_taken_ff;
  endsequence

  sequence load_finish;
    $rose(cfg_done_ff) ##1 init_done_ff;
  endsequence

  a_strap_map_load: assert property (strap_cycle |=> lane_bit_map_select_ff == $past(strap_pin_one))
    else $error("map select not loaded from strap");
  a_strap_pix_load: assert property (strap_cycle |=> input_pixel_mode_ff == $past(strap_pin_zero))
    else $error("pixel mode not loaded from strap");
  a_init_after_cfg: assert property ($rose(cfg_done_ff) |-> load_finish)
    else $error("init done did not follow config done");
  a_init_needs_cfg: assert property (init_done_ff |-> cfg_done_ff)
    else $error("init done without config done");
  a_reload_self_clear: assert property (
      (cfg_reload_ff && seq_finish && !(wr_ctl && reg_wdata[BIT_CFG_RELOAD]))
      |=> !cfg_reload_ff)
    else $error("reload bit not cleared at finish");
  a_reload_set_wins: assert property (wr_ctl && reg_wdata[BIT_CFG_RELOAD] |=> cfg_reload_ff)
    else $error("reload request lost");
  a_swap_single_port: assert property (
      input_port_swap_ff && input_pixel_mode_ff == PIX_SINGLE &&
      lane_bit_map_select_ff == MAP_OLDI
      |=> primary_word_ff == $past(port_b_lanes) && secondary_word_ff == '0)
    else $error("single mode swap not taking secondary port");
  a_swap_dual_ports: assert property (
      input_port_swap_ff && input_pixel_mode_ff == PIX_DUAL &&
      lane_bit_map_select_ff == MAP_OLDI
      |=> primary_word_ff == $past(port_b_lanes) &&
          secondary_word_ff == $past(port_a_lanes))
    else $error("dual mode swap not exchanging ports");
  a_audio_write: assert property (
      wr_aud |=> audio_source_ff == $past(reg_wdata[BIT_AUDIO_SRC])
      && tdm_serialize_ff == $past(reg_wdata[BIT_TDM_EN]))
    else $error("audio setup write not applied");
  a_split_write: assert property (wr_conv |=> tdm_split_ff == $past(reg_wdata[BIT_TDM_SPLIT]))
    else $error("split enable write not applied");
  a_reserved_read: assert property (
      reg_rd && reg_addr == OFS_VIDEO_CTL
      |=> reg_rdata_ff[4:2] == 3'h0 && reg_rdata_ff[0] == 1'b0)
    else $error("reserved bits read nonzero");
  a_cksum_result: assert property (
      reg_rd && reg_addr == OFS_INIT_STS
      |=> reg_rdata_ff[BIT_CKSUM_OK] == $past(cksum_ok))
    else $error("checksum status not reported");
  a_spwg_rotate: assert property (
      lane_bit_map_select_ff == MAP_SPWG && !input_port_swap_ff &&
      input_pixel_mode_ff == PIX_DUAL
      |=> primary_word_ff == {$past(port_a_lanes[W-Q-1:0]), $past(port_a_lanes[W-1:W-Q])})
    else $error("spwg arrangement not rotating lanes");
  a_oldi_pass: assert property (
      lane_bit_map_select_ff == MAP_OLDI && !input_port_swap_ff &&
      input_pixel_mode_ff == PIX_DUAL
      |=> primary_word_ff == $past(port_a_lanes) &&
          secondary_word_ff == $past(port_b_lanes))
    else $error("openldi arrangement not passing lanes");
  a_single_second_zero: assert property (
      input_pixel_mode_ff == PIX_SINGLE |=> secondary_word_ff == '0)
    else $error("single mode secondary word not zero");
  a_reset_defaults: assert property (
      !straps_taken_ff |-> audio_source_ff == RST_AUDIO_SRC && tdm_serialize_ff == RST_TDM_EN &&
      tdm_split_ff == RST_TDM_SPLIT && input_port_swap_ff == RST_PORT_SWAP &&
      cfg_reload_ff == RST_CFG_RELOAD)
    else $error("control bits not at reset values");
  a_ctl_write: assert property (
      wr_ctl |=> lane_bit_map_select_ff == $past(reg_wdata[BIT_MAP_SEL]) &&
      input_pixel_mode_ff == $past(reg_wdata[BIT_PIX_MODE]) &&
      input_port_swap_ff == $past(reg_wdata[BIT_PORT_SWAP]))
    else $error("video control write not applied");
  a_strap_hold: assert property (
      straps_taken_ff && !wr_ctl
      |=> $stable(lane_bit_map_select_ff) && $stable(input_pixel_mode_ff))
    else $error("strapped mode bits changed without a write");
  a_audio_hold: assert property (
      !wr_aud |=> $stable(audio_source_ff) && $stable(tdm_serialize_ff))
    else $error("audio setup changed without a write");
  a_split_hold: assert property (!wr_conv |=> $stable(tdm_split_ff))
    else $error("split enable changed without a write");
  a_unmapped_read: assert property (
      reg_rd && reg_addr != OFS_VIDEO_CTL && reg_addr != OFS_INIT_STS &&
      reg_addr != OFS_AUDIO_SET && reg_addr != OFS_AUDIO_CONV
      |=> reg_rdata_ff == 8'h00)
    else $error("unmapped offset read nonzero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_ff))
    else $error("read data changed without a read");
  a_status_reserved: assert property (
      reg_rd && reg_addr == OFS_INIT_STS
      |=> reg_rdata_ff[7:5] == 3'h0 && reg_rdata_ff[3] == 1'b0 && reg_rdata_ff[0] == 1'b0)
    else $error("status reserved bits read nonzero");
  a_audio_reserved: assert property (
      reg_rd && reg_addr == OFS_AUDIO_SET
      |=> reg_rdata_ff[7:3] == 5'h00 && reg_rdata_ff[0] == 1'b0)
    else $error("audio setup reserved bits read nonzero");
  a_conv_reserved: assert property (
      reg_rd && reg_addr == OFS_AUDIO_CONV |=> reg_rdata_ff[6:0] == 7'h00)
    else $error("conversion reserved bits read nonzero");
  a_nvm_rd_pulse: assert property (nvm_rd_ff |=> !nvm_rd_ff)
    else $error("memory read request longer than one cycle");
  a_nvm_addr_window: assert property (
      nvm_rd_ff |-> int'(nvm_addr_ff) >= (1 << AW) - CKSUM_BYTES)
    else $error("memory read outside checksum area");
endmodule // bridge_control_status_regs

// >>> bridge_regs_pkg.sv
// offsets, field positions, reset values and sizes of the bridge control registers
package bridge_regs_pkg;
  localparam logic [7:0] OFS_VIDEO_CTL  = 8'h4f;
  localparam logic [7:0] OFS_INIT_STS   = 8'h50;
  localparam logic [7:0] OFS_AUDIO_SET  = 8'h54;
  localparam logic [7:0] OFS_AUDIO_CONV = 8'h55;

  localparam int BIT_MAP_SEL    = 7;
  localparam int BIT_PIX_MODE   = 6;
  localparam int BIT_PORT_SWAP  = 5;
  localparam int BIT_CFG_RELOAD = 1;
  localparam int BIT_INIT_DONE  = 4;
  localparam int BIT_CFG_DONE   = 2;
  localparam int BIT_CKSUM_OK   = 1;
  localparam int BIT_TDM_EN     = 2;
  localparam int BIT_AUDIO_SRC  = 1;
  localparam int BIT_TDM_SPLIT  = 7;

  localparam logic RST_PORT_SWAP  = 1'b0;
  localparam logic RST_CFG_RELOAD = 1'b0;
  localparam logic RST_CFG_DONE   = 1'b0;
  localparam logic RST_INIT_DONE  = 1'b0;
  localparam logic RST_CKSUM_OK   = 1'b1;
  localparam logic RST_TDM_EN     = 1'b0;
  localparam logic RST_AUDIO_SRC  = 1'b1;
  localparam logic RST_TDM_SPLIT  = 1'b0;

  localparam logic PIX_DUAL   = 1'b0;
  localparam logic PIX_SINGLE = 1'b1;
  localparam logic MAP_SPWG   = 1'b0;
  localparam logic MAP_OLDI   = 1'b1;

  localparam int CKSUM_BYTES = 128;
  localparam int NVM_AW      = 8;
  localparam int LANE_W      = 28;
endpackage

// >>> nvm_cksum_seq.sv
// configuration load sequence: reads the checksum area of the memory and flags completion
`timescale 1ns/1ps
module nvm_cksum_seq
  import bridge_regs_pkg::*;
#(
  parameter int AW = NVM_AW
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          start_req,
  input  wire logic [7:0]    nvm_rdata,
  input  wire logic          nvm_valid,
  output logic               nvm_rd_ff,
  output logic      [AW-1:0] nvm_addr_ff,
  output logic               cfg_done_ff,
  output logic               init_done_ff,
  output logic               cksum_ok_ff,
  output logic               seq_finish
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_REQ  = 4'h2,
    S_WAIT = 4'h4,
    S_CFG  = 4'h8
  } seq_state_t;

  localparam logic [AW-1:0] FIRST_ADDR = AW'((1 << AW) - CKSUM_BYTES);
  localparam logic [AW-1:0] LAST_ADDR  = '1;

  seq_state_t    state_ff;
  seq_state_t    nxt_state;
  logic [7:0]    sum_ff;
  logic [7:0]    nxt_sum;
  logic [AW-1:0] nxt_nvm_addr;
  logic          nxt_nvm_rd;
  logic          nxt_cfg_done;
  logic          nxt_init_done;
  logic          nxt_cksum_ok;

  assign seq_finish = (state_ff == S_CFG);

  always_comb begin
    nxt_state     = state_ff;
    nxt_sum       = sum_ff;
    nxt_nvm_addr  = nvm_addr_ff;
    nxt_nvm_rd    = 1'b0;
    nxt_cfg_done  = cfg_done_ff;
    nxt_init_done = init_done_ff;
    nxt_cksum_ok  = cksum_ok_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (start_req) begin
          nxt_state     = S_REQ;
          nxt_sum       = 8'h00;
          nxt_nvm_addr  = FIRST_ADDR;
          nxt_cfg_done  = 1'b0;
          nxt_init_done = 1'b0;
        end
      end
      S_REQ: begin
        nxt_nvm_rd = 1'b1;
        nxt_state  = S_WAIT;
      end
      S_WAIT: begin
        if (nvm_valid) begin
          nxt_sum = sum_ff + nvm_rdata;
          if (nvm_addr_ff == LAST_ADDR) begin
            nxt_state    = S_CFG;
            nxt_cfg_done = 1'b1;
            nxt_cksum_ok = ((sum_ff + nvm_rdata) == 8'h00);
          end else begin
            nxt_nvm_addr = nvm_addr_ff + 1'b1;
            nxt_state    = S_REQ;
          end
        end
      end
      S_CFG: begin
        nxt_init_done = 1'b1;
        nxt_state     = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= S_IDLE;
      sum_ff       <= 8'h00;
      nvm_addr_ff  <= '0;
      nvm_rd_ff    <= 1'b0;
      cfg_done_ff  <= RST_CFG_DONE;
      init_done_ff <= RST_INIT_DONE;
      cksum_ok_ff  <= RST_CKSUM_OK;
    end else begin
      state_ff     <= nxt_state;
      sum_ff       <= nxt_sum;
      nvm_addr_ff  <= nxt_nvm_addr;
      nvm_rd_ff    <= nxt_nvm_rd;
      cfg_done_ff  <= nxt_cfg_done;
      init_done_ff <= nxt_init_done;
      cksum_ok_ff  <= nxt_cksum_ok;
    end
  end
endmodule // nvm_cksum_seq

// >>> nvm_model.sv
// behavioural non-volatile memory answering the bridge's configuration reads
`timescale 1ns/1ps
module nvm_model (
  input  wire logic       clock,
  input  wire logic       rd,
  input  wire logic [7:0] addr,
  input  wire logic       slow,
  input  wire logic       bad,
  output logic            valid,
  output logic      [7:0] rdata
);
  logic [7:0] addr_q;
  logic [7:0] last;
  int         cnt;

  // byte pairs cancel, so the top 128 bytes sum to zero unless bad is set
  function automatic logic [7:0] byte_at(input logic [7:0] a, input logic b);
    logic [7:0] v;
    v = a[0] ? 8'(8'h00 - (a - 8'h01)) : a;
    if (a == 8'hff && b) v = v + 8'h01;
    return v;
  endfunction

  initial begin
    valid = 1'b0;
    rdata = 8'h00;
    last  = 8'h00;
    cnt   = 0;
  end

  // idle data bus shows the inverse of the last byte, never a stale copy
  always @(posedge clock) begin
    valid <= 1'b0;
    rdata <= ~last;
    if (rd && !slow) begin
      valid <= 1'b1;
      rdata <= byte_at(addr, bad);
      last  <= byte_at(addr, bad);
    end else if (rd) begin
      cnt    <= 3;
      addr_q <= addr;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        valid <= 1'b1;
        rdata <= byte_at(addr_q, bad);
        last  <= byte_at(addr_q, bad);
      end
    end
  end
endmodule // nvm_model

// >>> test_bridge_control_status_regs.sv
// self-checking testbench of the bridge control and status registers
`timescale 1ns/1ps
module test_bridge_control_status_regs
  import bridge_regs_pkg::*;
;
  logic              clock, nrst, reg_wr, reg_rd, slow, bad, nvm_valid;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata_ff, nvm_rdata, nvm_addr_ff, exp_addr;
  logic [LANE_W-1:0] pa, pb, primary_word_ff, secondary_word_ff, ep, es;
  logic              nvm_rd_ff, cfg_done_ff, init_done_ff, map_q, pix_q, swap_q;
  logic              strap_one, strap_zero;
  logic              audio_source_ff, tdm_serialize_ff, tdm_split_ff;
  logic [2:0]        mps;
  int                n_fail, checked;

  bridge_control_status_regs dut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .strap_pin_one(strap_one), .strap_pin_zero(strap_zero),
    .port_a_lanes(pa), .port_b_lanes(pb),
    .primary_word_ff(primary_word_ff), .secondary_word_ff(secondary_word_ff),
    .nvm_rd_ff(nvm_rd_ff), .nvm_addr_ff(nvm_addr_ff), .nvm_rdata(nvm_rdata),
    .nvm_valid(nvm_valid), .cfg_done_ff(cfg_done_ff), .init_done_ff(init_done_ff),
    .lane_bit_map_select_ff(map_q), .input_pixel_mode_ff(pix_q),
    .input_port_swap_ff(swap_q), .audio_source_ff(audio_source_ff),
    .tdm_serialize_ff(tdm_serialize_ff), .tdm_split_ff(tdm_split_ff)
  );

  nvm_model nvm (
    .clock(clock), .rd(nvm_rd_ff), .addr(nvm_addr_ff), .slow(slow), .bad(bad),
    .valid(nvm_valid), .rdata(nvm_rdata)
  );

  always #25 clock = ~clock;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [LANE_W-1:0] exp,
                          input logic [LANE_W-1:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk_byte(what, exp, reg_rdata_ff);
  endtask

  // bounded wait for initialization; notes whether config done led it
  task automatic wait_init();
    int   k;
    logic saw;
    saw = 1'b0;
    for (k = 0; k < 4000 && init_done_ff !== 1'b1; k++) begin
      @(negedge clock);
      if (cfg_done_ff === 1'b1 && init_done_ff !== 1'b1) saw = 1'b1;
    end
    if (init_done_ff !== 1'b1) begin
      n_fail++;
      $display("FAIL init_done expected 1 seen %b", init_done_ff);
      give_verdict();
    end else begin
      chk_byte("cfg_before_init", 8'h01, {7'h00, saw});
    end
  endtask

  // memory reads walk the top 128 bytes in ascending order
  always @(negedge clock) begin
    if (nvm_rd_ff === 1'b1) begin
      chk_byte("nvm_addr", exp_addr, nvm_addr_ff);
      exp_addr <= (exp_addr == 8'hff) ? 8'h80 : exp_addr + 8'h01;
    end
  end

  initial begin
    clock = 1'b0; nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; slow = 1'b0; bad = 1'b0;
    pa = 28'h123_4567; pb = 28'h89a_bcde; exp_addr = 8'h80;
    strap_one = 1'b1;
    strap_zero = 1'b0;
    n_fail = 0; checked = 0;
    @(negedge clock);
    chk_byte("audio_src_rst", 8'h01, {7'h00, audio_source_ff});
    @(negedge clock);
    nrst = 1'b1;
    wait_init();
    rd_chk(OFS_VIDEO_CTL, 8'h80, "video_ctl_rst");
    rd_chk(OFS_INIT_STS, 8'h16, "init_sts_rst");
    rd_chk(OFS_AUDIO_SET, 8'h02, "audio_set_rst");
    rd_chk(OFS_AUDIO_CONV, 8'h00, "audio_conv_rst");
    wr(OFS_AUDIO_SET, 8'h04);
    chk_byte("audio_outs", 8'h02, {6'h00, tdm_serialize_ff, audio_source_ff});
    wr(OFS_AUDIO_SET, 8'hff);
    rd_chk(OFS_AUDIO_SET, 8'h06, "audio_set_all");
    chk_byte("audio_outs_on", 8'h03, {6'h00, tdm_serialize_ff, audio_source_ff});
    wr(OFS_AUDIO_CONV, 8'hff);
    rd_chk(OFS_AUDIO_CONV, 8'h80, "audio_conv_all");
    chk_byte("split_out", 8'h01, {7'h00, tdm_split_ff});
    wr(OFS_AUDIO_CONV, 8'h00);
    chk_byte("split_off", 8'h00, {7'h00, tdm_split_ff});
    wr(OFS_INIT_STS, 8'hff);
    rd_chk(OFS_INIT_STS, 8'h16, "sts_write_ignored");
    rd_chk(8'h51, 8'h00, "unmapped_read");
    for (int i = 0; i < 8; i++) begin
      mps = i[2:0];
      wr(OFS_VIDEO_CTL, {mps, 5'h1d});
      repeat (2) @(negedge clock);
      ep = mps[0] ? pb : pa;
      es = mps[1] ? 28'h000_0000 : (mps[0] ? pa : pb);
      if (!mps[2]) begin
        ep = {ep[20:0], ep[27:21]};
        es = {es[20:0], es[27:21]};
      end
      chk_word("primary", ep, primary_word_ff);
      chk_word("secondary", es, secondary_word_ff);
      chk_byte("ctl_outs", {5'h00, mps}, {5'h00, map_q, pix_q, swap_q});
      rd_chk(OFS_VIDEO_CTL, {mps, 5'h00}, "video_ctl_rw");
    end
    slow = 1'b1;
    bad  = 1'b1;
    wr(OFS_VIDEO_CTL, 8'h82);
    repeat (3) @(negedge clock);
    rd_chk(OFS_VIDEO_CTL, 8'h82, "reload_busy");
    chk_byte("cfg_drop", 8'h00, {7'h00, cfg_done_ff});
    wait_init();
    rd_chk(OFS_INIT_STS, 8'h14, "cksum_fail");
    rd_chk(OFS_VIDEO_CTL, 8'h80, "reload_clear");
    slow = 1'b0;
    bad  = 1'b0;
    wr(OFS_VIDEO_CTL, 8'h82);
    repeat (3) @(negedge clock);
    wait_init();
    rd_chk(OFS_INIT_STS, 8'h16, "cksum_pass");
    // second reset in mid-run with the other strap levels
    @(negedge clock);
    nrst = 1'b0;
    strap_one = 1'b0;
    strap_zero = 1'b1;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    wait_init();
    rd_chk(OFS_VIDEO_CTL, 8'h40, "video_ctl_strap2");
    chk_word("secondary_strap2", 28'h000_0000, secondary_word_ff);
    rd_chk(OFS_AUDIO_SET, 8'h02, "audio_set_rst2");
    rd_chk(OFS_INIT_STS, 8'h16, "init_sts_rst2");
    give_verdict();
  end
endmodule // test_bridge_control_status_regs

// >>> video_port_steer.sv
// input port exchange and lane bit arrangement for the video receiver
`timescale 1ns/1ps
module video_port_steer
  import bridge_regs_pkg::*;
#(
  parameter int W = LANE_W
) (
  input  wire logic         lane_bit_map_select,
  input  wire logic         input_pixel_mode,
  input  wire logic         input_port_swap,
  input  wire logic [W-1:0] port_a_lanes,
  input  wire logic [W-1:0] port_b_lanes,
  output logic      [W-1:0] primary_word,
  output logic      [W-1:0] secondary_word
);
  localparam int Q = W / 4;

  logic [W-1:0] src_a;
  logic [W-1:0] src_b;

  always_comb begin
    src_a = port_a_lanes;
    src_b = port_b_lanes;
    if (input_port_swap) begin
      src_a = port_b_lanes;
      src_b = (input_pixel_mode == PIX_SINGLE) ? '0 : port_a_lanes;
    end else if (input_pixel_mode == PIX_SINGLE) begin
      src_b = '0;
    end
  end

  // last lane carries color msbs in one arrangement and lsbs in the other
  always_comb begin
    if (lane_bit_map_select == MAP_OLDI) begin
      primary_word   = src_a;
      secondary_word = src_b;
    end else begin
      primary_word   = {src_a[W-Q-1:0], src_a[W-1:W-Q]};
      secondary_word = {src_b[W-Q-1:0], src_b[W-1:W-Q]};
    end
  end
endmodule // video_port_steer
